// >>> rtl/adcsq_seq.sv
`timescale 1ns/10ps
module adcsq_seq
   import adcsq_pkg::*;
#(
   parameter bit DUAL_NOTCH = 1'b0,
   parameter int CONV_CYC_LOW = (DUAL_NOTCH ? CONV_CYC_DN : CONV_CYC_SN_LOW),
   parameter int CONV_CYC_HIGH = (DUAL_NOTCH ? CONV_CYC_DN : CONV_CYC_SN_HIGH),
   parameter int OSC_DIV = (DUAL_NOTCH ? OSC_DIV_DN : OSC_DIV_SN),
   parameter int EXT_LOSS = EXT_LOSS_CYC,
   parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   output logic sdo_o,
   output logic sdo_oe_o,
   input wire logic rejection_select_pin_i,
   input wire logic [RESULT_BITS:0] sample_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   output logic ext_clk_active_o,
   output logic converting_o
);

   initial begin
      if (CONV_CYC_LOW < 1 || CONV_CYC_HIGH < 1 || OSC_DIV < 1 || EXT_LOSS < 2)
         $error("Timing parameters must be positive");
   end

   // ==========================================================================
   // Pin synchronisers.
   // ==========================================================================
   logic [1:0] cs_sync_r;
   logic [1:0] sck_sync_r;
   logic [1:0] rsel_sync_r;
   logic cs_d_r;
   logic sck_d_r;
   logic rsel_d_r;

   // Reset values match the idle pin levels, so no false edge follows reset.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cs_sync_r <= 2'h3;
         sck_sync_r <= 2'h3;
         rsel_sync_r <= 2'h0;
         cs_d_r <= 1'b1;
         sck_d_r <= 1'b1;
         rsel_d_r <= 1'b0;
      end else begin
         cs_sync_r <= {cs_sync_r[0], cs_n_i};
         sck_sync_r <= {sck_sync_r[0], sck_i};
         rsel_sync_r <= {rsel_sync_r[0], rejection_select_pin_i};
         cs_d_r <= cs_sync_r[1];
         sck_d_r <= sck_sync_r[1];
         rsel_d_r <= rsel_sync_r[1];
      end
   end

   logic cs_n;
   logic cs_fall;
   logic cs_rise;
   logic sck_in_rise;
   logic sck_in_fall;
   logic rsel_rise;

   assign cs_n = cs_sync_r[1];
   assign cs_fall = cs_d_r && !cs_n;
   assign cs_rise = !cs_d_r && cs_n;
   assign sck_in_rise = !sck_d_r && sck_sync_r[1];
   assign sck_in_fall = sck_d_r && !sck_sync_r[1];
   assign rsel_rise = !rsel_d_r && rsel_sync_r[1];

   // ==========================================================================
   // External conversion clock detection and conversion clock tick.
   // ==========================================================================
   logic [$clog2(EXT_LOSS+1)-1:0] loss_cnt_r;
   logic ext_act_r;
   logic [$clog2(OSC_DIV+1)-1:0] osc_cnt_r;
   logic conv_tick;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         loss_cnt_r <= '0;
         ext_act_r <= 1'b0;
      end else if (rsel_rise) begin
         // Two rising edges within the loss window mark a clock of 5 kHz or more.
         ext_act_r <= (loss_cnt_r != '0);
         loss_cnt_r <= ($clog2(EXT_LOSS+1))'(EXT_LOSS);
      end else if (loss_cnt_r != '0) begin
         loss_cnt_r <= loss_cnt_r - 1'b1;
      end else begin
         ext_act_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || ext_act_r) begin
         osc_cnt_r <= '0;
      end else if (osc_cnt_r == ($clog2(OSC_DIV+1))'(OSC_DIV - 1)) begin
         osc_cnt_r <= '0;
      end else begin
         osc_cnt_r <= osc_cnt_r + 1'b1;
      end
   end

   // The internal oscillator is switched off while an external clock is present.
   assign conv_tick = ext_act_r ? rsel_rise : (osc_cnt_r == ($clog2(OSC_DIV+1))'(OSC_DIV - 1));
   assign ext_clk_active_o = ext_act_r;

   // ==========================================================================
   // Result buffer between the modulator and the output shift register.
   // ==========================================================================
   adcsq_result_t fifo_out;
   logic fifo_valid;
   logic fifo_pop;

   adcsq_fifo #(
      .WIDTH(RESULT_BITS + 1),
      .DEPTH(FIFO_DEPTH_P)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_data_i(sample_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(sample_ready_o),
      .out_data_o(fifo_out),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop)
   );

   // ==========================================================================
   // Conversion sequencer.
   // ==========================================================================
   localparam int CW = 32;
   adcsq_state_t state_r;
   logic [CW-1:0] conv_cnt_r;
   logic [CW-1:0] conv_len;
   logic conv_done;
   logic int_mode_r;
   logic [4:0] bit_cnt_r;
   logic [2:0] sdiv_cnt_r;
   logic sck_int_r;
   logic data_begun_r;
   logic start_conv;
   logic shift_edge;
   logic rise_edge;
   adcsq_frame_t frame_r;
   logic [1:0] hold_r;

   // Conversion length: internal oscillator by pin level, external by clock periods.
   always_comb begin
      if (ext_act_r) begin
         conv_len = CW'(EXT_CONV_PERIODS);
      end else if (rsel_sync_r[1] && !DUAL_NOTCH) begin
         conv_len = CW'(CONV_CYC_HIGH);
      end else begin
         conv_len = CW'(CONV_CYC_LOW);
      end
   end

   // External clock counts its own periods; internal counts system cycles.
   // Losing the external clock mid-conversion falls back to the internal count.
   logic conv_step;
   assign conv_step = ext_act_r ? rsel_rise : 1'b1;
   assign conv_done = (state_r == ST_CONVERT) && conv_step && (conv_cnt_r + 1'b1 >= conv_len);

   // Internal serial clock ticks: one half period per four conversion clock ticks.
   logic sck_half_tick;
   // The divider restarts with every frame, so the first half period may be short.
   assign sck_half_tick = conv_tick && (sdiv_cnt_r == 3'(SCK_DIV / 2 - 1));
   assign rise_edge = int_mode_r ? (sck_half_tick && !sck_int_r) : sck_in_rise;
   assign shift_edge = int_mode_r ? (sck_half_tick && sck_int_r) : sck_in_fall;

   // Abort after the data phase began, or end on the first falling edge (internal: half tick) after the 24th rising edge.
   assign start_conv = (state_r == ST_DATA) && ((cs_rise && data_begun_r)
      || (data_begun_r && bit_cnt_r == 5'(FRAME_BITS) && (int_mode_r ? sck_half_tick : shift_edge)));

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         int_mode_r <= 1'b1;
      end else if (hold_r == 2'h1) begin
         int_mode_r <= sck_sync_r[1];
      end else if (cs_fall && state_r != ST_DATA) begin
         int_mode_r <= sck_sync_r[1];
      end
   end

   // Power-up strap capture: the synchronised pin is valid on the third edge after reset.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         hold_r <= 2'h3;
      end else if (hold_r != 2'h0) begin
         hold_r <= hold_r - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_r <= ST_CONVERT;
         conv_cnt_r <= '0;
      end else begin
         case (state_r)
            ST_CONVERT: begin
               if (conv_done) begin
                  conv_cnt_r <= '0;
                  state_r <= ST_SLEEP;
               end else if (conv_step) begin
                  conv_cnt_r <= conv_cnt_r + 1'b1;
               end
            end
            ST_SLEEP: begin
               // Sleep holds while chip select is high; low enters data output.
               if (!cs_n) state_r <= ST_DATA;
            end
            ST_DATA: begin
               if (start_conv) begin
                  state_r <= ST_CONVERT;
               end else if (cs_n && !data_begun_r) begin
                  state_r <= ST_SLEEP;
               end
            end
            default: state_r <= ST_CONVERT;
         endcase
      end
   end

   // Oldest buffered result is latched into the frame at end of conversion.
   assign fifo_pop = conv_done && fifo_valid;

   // Most recent popped result; it repeats when the modulator has not delivered a new one.
   adcsq_result_t last_res_r;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         last_res_r <= '0;
      end else if (fifo_pop) begin
         last_res_r <= fifo_out;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         frame_r <= '0;
         bit_cnt_r <= '0;
         data_begun_r <= 1'b0;
      end else if (conv_done) begin
         frame_r.done_n <= 1'b0;
         frame_r.dummy_bit <= DUMMY_BIT_VAL;
         if (fifo_valid) begin
            frame_r.sign_bit <= fifo_out.sign_bit;
            frame_r.value <= fifo_out.value;
         end else begin
            frame_r.sign_bit <= last_res_r.sign_bit;
            frame_r.value <= last_res_r.value;
         end
         bit_cnt_r <= '0;
         data_begun_r <= 1'b0;
      end else if (start_conv || state_r != ST_DATA) begin
         bit_cnt_r <= '0;
         data_begun_r <= 1'b0;
      end else begin
         if (rise_edge && !cs_n) begin
            data_begun_r <= 1'b1;
            bit_cnt_r <= bit_cnt_r + 1'b1;
         end
         // The first internal falling edge comes before any rising edge and shifts nothing.
         if (shift_edge && data_begun_r) begin
            frame_r <= {frame_r[FRAME_BITS-2:0], 1'b0};
         end
      end
   end

   // Internal serial clock: conversion clock divided by eight, high when idle.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sdiv_cnt_r <= '0;
         sck_int_r <= 1'b1;
      end else if (!int_mode_r || state_r != ST_DATA || start_conv) begin
         sdiv_cnt_r <= '0;
         sck_int_r <= !(int_mode_r && state_r == ST_DATA && !cs_n && !start_conv && !data_begun_r);
      end else if (conv_tick) begin
         if (sdiv_cnt_r == 3'(SCK_DIV / 2 - 1)) begin
            sdiv_cnt_r <= '0;
         end else begin
            sdiv_cnt_r <= sdiv_cnt_r + 1'b1;
         end
         if (sck_half_tick && bit_cnt_r != 5'(FRAME_BITS)) begin
            sck_int_r <= !sck_int_r;
         end
      end
   end

   // ==========================================================================
   // Pin drivers.
   // ==========================================================================
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sdo_o <= 1'b1;
         sdo_oe_o <= 1'b0;
         sck_o <= 1'b1;
         sck_oe_o <= 1'b0;
      end else begin
         sdo_oe_o <= !cs_n;
         if (state_r == ST_DATA && !start_conv) begin
            sdo_o <= frame_r.done_n;
         end else begin
            sdo_o <= (state_r == ST_CONVERT) || start_conv;
         end
         // The driver waits out the chip-select fall so that a stale mode never drives the pin.
         sck_oe_o <= int_mode_r && !cs_n && !cs_fall;
         sck_o <= sck_int_r;
      end
   end

   assign converting_o = (state_r == ST_CONVERT);

endmodule : adcsq_seq

// >>> rtl/adcsq_pkg.sv
package adcsq_pkg;

   // System clock period, in ns, and pin-level timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_TIME_SN_LOW_MS = 67;
   localparam int CONV_TIME_SN_HIGH_MS = 80;
   localparam int CONV_TIME_DN_MS = 73;
   localparam int CONV_CYC_SN_LOW = CONV_TIME_SN_LOW_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CONV_CYC_SN_HIGH = CONV_TIME_SN_HIGH_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CONV_CYC_DN = CONV_TIME_DN_MS * 1000000 / CLK_PERIOD_NS;
   localparam int DOUT_TIME_SN_US = 1250;
   localparam int DOUT_TIME_DN_US = 1400;
   // Internal oscillator period in system cycles: 24 SCK cycles of 8 osc periods fit the output time.
   localparam int OSC_DIV_SN = DOUT_TIME_SN_US * 1000 / CLK_PERIOD_NS / 192;
   localparam int OSC_DIV_DN = DOUT_TIME_DN_US * 1000 / CLK_PERIOD_NS / 192;
   localparam int EXT_CONV_PERIODS = 10278;
   localparam int NOTCH_DIV = 2560;
   localparam int SCK_DIV = 8;
   localparam int FRAME_BITS = 24;
   localparam int RESULT_BITS = 21;
   localparam int EXT_MIN_FREQ_KHZ = 5;
   // An external conversion clock is lost if no edge is seen within one 5 kHz period.
   localparam int EXT_LOSS_CYC = 1000000 / (EXT_MIN_FREQ_KHZ * CLK_PERIOD_NS);
   localparam logic DUMMY_BIT_VAL = 1'b0;
   localparam int FIFO_DEPTH = 8;

   typedef struct packed {
      logic sign_bit;
      logic [RESULT_BITS-1:0] value;
   } adcsq_result_t;

   typedef struct packed {
      logic done_n;
      logic dummy_bit;
      logic sign_bit;
      logic [RESULT_BITS-1:0] value;
   } adcsq_frame_t;

   typedef enum logic [1:0] {
      ST_CONVERT,
      ST_SLEEP,
      ST_DATA
   } adcsq_state_t;

endpackage : adcsq_pkg

// >>> rtl/adcsq_fifo.sv
`timescale 1ns/10ps
module adcsq_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic do_wr;
   logic do_rd;

   assign in_ready_o = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr_r != rd_ptr_r;
   assign do_wr = in_valid_i && in_ready_o;
   assign do_rd = out_valid_o && out_ready_i;
   assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge clk_sys_i) begin
      if (do_wr) begin
         mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (do_wr) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (do_rd) rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end

endmodule : adcsq_fifo

// >>> tb/adcsq_chk.sv
`timescale 1ns/10ps
// ==========================================
// Pin-level timing properties.
module adcsq_chk #(
   parameter int OSC_DIV = 2,
   parameter int CONV_CYC_LOW = 50,
   parameter int CONV_CYC_HIGH = 60
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic sdo_o,
   input wire logic sdo_oe_o,
   input wire logic ext_clk_active_o,
   input wire logic converting_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   int conv_r;
   int hi_r;
   logic seen_low_r;
   always_ff @(posedge clk_sys_i) begin
      conv_r <= (rst_i || !converting_o) ? 0 : conv_r + 1;
   end
   always_ff @(posedge clk_sys_i) begin
      hi_r <= (rst_i || !sck_o) ? 0 : hi_r + 1;
   end
   // The first falling edge of a frame ends the idle-high level, so only later ones are timed.
   always_ff @(posedge clk_sys_i) begin
      seen_low_r <= (rst_i || !sck_oe_o || converting_o) ? 1'b0 : (seen_low_r || !sck_o);
   end
   a_oe_follows_cs: assert property (cs_n_i [*5] |-> !sdo_oe_o)
      else $error("data output driven while deselected");
   a_sck_drive_cs: assert property (cs_n_i [*5] |-> !sck_oe_o)
      else $error("serial clock driven while deselected");
   a_sdo_on_fall: assert property (sck_oe_o && sck_o && $past(sck_o) && !converting_o
      && !$past(converting_o) && !$past(converting_o, 2) |-> $stable(sdo_o))
      else $error("data changed while serial clock high");
   a_sck_high_phase: assert property ($fell(sck_o) && sck_oe_o && $past(sck_oe_o, 2) && seen_low_r
      |-> hi_r == 4 * OSC_DIV)
      else $error("serial clock high phase wrong");
   a_conv_length: assert property ($fell(converting_o) && !ext_clk_active_o
      |-> conv_r == CONV_CYC_LOW || conv_r == CONV_CYC_HIGH)
      else $error("conversion length wrong");
   a_done_high_conv: assert property ((converting_o && !cs_n_i) [*5] |-> sdo_o)
      else $error("done flag low while converting");
   a_done_low_sleep: assert property ($fell(converting_o) && !cs_n_i |-> ##[1:5] (!sdo_o || cs_n_i))
      else $error("done flag not low after conversion");
   a_reset_idle: assert property (disable iff (1'h0) rst_i |=> !sdo_oe_o && !sck_oe_o && sck_o)
      else $error("outputs not idle in reset");
endmodule : adcsq_chk

bind adcsq_seq adcsq_chk #(.OSC_DIV(OSC_DIV), .CONV_CYC_LOW(CONV_CYC_LOW), .CONV_CYC_HIGH(CONV_CYC_HIGH)) chk (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_o(sdo_o),
   .sdo_oe_o(sdo_oe_o), .ext_clk_active_o(ext_clk_active_o), .converting_o(converting_o));

// >>> tb/adcsq_host.sv
`timescale 1ns/10ps
// ==========================================
// Host side: chip select and serial clock master.
module adcsq_host #(
   parameter int HALF = 6
) (
   input wire logic clk_sys_i,
   input wire logic sdo_i,
   input wire logic sck_pin_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic sck_en_o
);
   int tmo = 0;
   initial begin
      cs_n_o = 1'h1;
      sck_o = 1'h0;
      sck_en_o = 1'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : tick
   // Serial clock level at the chip-select fall picks the clock source; a released pin reads high.
   task automatic xfer(input bit int_sck, input int nbits, output logic [23:0] f);
      int w;
      logic prev;
      f = '0;
      sck_o = 1'h0;
      sck_en_o = !int_sck;
      tick(2);
      cs_n_o = 1'h0;
      tick(6);
      w = 0;
      while (sdo_i !== 1'h0 && w < 3000) begin
         tick(1);
         w++;
      end
      if (w == 3000) tmo++;
      for (int i = 0; i < nbits; i++) begin
         if (int_sck) begin
            w = 0;
            prev = sck_pin_i;
            tick(1);
            while (!(prev === 1'h0 && sck_pin_i === 1'h1) && w < 200) begin
               prev = sck_pin_i;
               tick(1);
               w++;
            end
            if (w == 200) tmo++;
            f = {f[22:0], sdo_i};
         end else begin
            tick(HALF);
            f = {f[22:0], sdo_i};
            sck_o = 1'h1;
            tick(HALF);
            sck_o = 1'h0;
         end
      end
      tick(HALF);
   endtask : xfer
   task automatic release_cs();
      cs_n_o = 1'h1;
      sck_en_o = 1'h0;
      tick(1);
   endtask : release_cs
endmodule : adcsq_host

// >>> tb/adc_serial_readout_sequencer_bench.sv
`timescale 1ns/10ps
module adc_serial_readout_sequencer_bench
   import adcsq_pkg::*;
;
   localparam int CONV_LO = 50;
   localparam int CONV_HI = 60;
   logic clk_sys_i = 1'h0;
   logic rst_i;
   logic rej;
   logic [RESULT_BITS:0] sample;
   logic valid;
   logic sdo_last = 1'h0;
   logic ready, ext_act, conv, sck_o, sck_oe, sdo_o, sdo_oe, cs_n, h_sck, h_sck_en;
   // A released data line shows the inverse of its last driven level; a released clock line reads high.
   wire logic sck_pin = sck_oe ? sck_o : (h_sck_en ? h_sck : 1'h1);
   wire logic sdo_pin = sdo_oe ? sdo_o : ~sdo_last;
   int n_errors = 0;
   int checks = 0;
   int seed = 32'hB42A;
   int run = 0;
   int last_run = 0;
   int w;
   logic [RESULT_BITS:0] q[$];
   logic [RESULT_BITS:0] cur;
   logic [23:0] f;
   always #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      if (sdo_oe) sdo_last <= sdo_o;
      if (conv === 1'h1) run <= run + 1;
      else if (run != 0) begin
         last_run <= run;
         run <= 0;
      end
   end
   adcsq_seq #(.CONV_CYC_LOW(CONV_LO), .CONV_CYC_HIGH(CONV_HI), .OSC_DIV(2), .EXT_LOSS(200)) uut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_o(sck_oe),
      .sdo_o(sdo_o), .sdo_oe_o(sdo_oe), .rejection_select_pin_i(rej), .sample_i(sample), .sample_valid_i(valid),
      .sample_ready_o(ready), .ext_clk_active_o(ext_act), .converting_o(conv));
   adcsq_host #(.HALF(6)) host (.clk_sys_i(clk_sys_i), .sdo_i(sdo_pin), .sck_pin_i(sck_pin), .cs_n_o(cs_n),
      .sck_o(h_sck), .sck_en_o(h_sck_en));
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic conclude();
      n_errors += host.tmo;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic wait_conv(input logic v, input int lim);
      int n;
      n = 0;
      while (conv !== v && n < lim) begin
         host.tick(1);
         n++;
      end
      if (n == lim) begin
         n_errors++;
         conclude();
      end
   endtask : wait_conv
   task automatic rd(input bit int_sck, input string nm);
      host.xfer(int_sck, 24, f);
      check(nm, f, {1'h0, DUMMY_BIT_VAL, cur});
      if (q.size() != 0) cur = q.pop_front();
   endtask : rd
   initial begin
      #600000;
      n_errors++;
      conclude();
   end
   initial begin
      rst_i = 1'h1;
      rej = 1'h0;
      sample = '0;
      valid = 1'h0;
      host.tick(12);
      rst_i = 1'h0;
      for (int i = 0; i < 9; i++) begin
         sample = (RESULT_BITS + 1)'($random(seed));
         valid = 1'h1;
         if (i == 8) check("ready when full", ready, 1'h0);
         w = 0;
         while (ready !== 1'h1 && w < 100) begin
            host.tick(1);
            w++;
         end
         q.push_back(sample);
         host.tick(1);
      end
      valid = 1'h0;
      cur = q.pop_front();
      rd(1'h0, "ext frame");
      check("done after 24th fall", {sdo_pin, conv}, 2'h3);
      wait_conv(1'h0, 200);
      host.tick(6);
      check("done while selected", sdo_pin, 1'h0);
      check("conv length low", last_run, CONV_LO);
      host.release_cs();
      host.tick(5);
      check("sdo released", sdo_oe, 1'h0);
      rej = 1'h1;
      rd(1'h0, "ext frame high");
      host.release_cs();
      wait_conv(1'h1, 20);
      wait_conv(1'h0, 200);
      host.tick(2);
      check("conv length high", last_run, CONV_HI);
      rej = 1'h0;
      host.xfer(1'h0, 5, f);
      check("abort bits", f[4:0], {1'h0, DUMMY_BIT_VAL, cur[RESULT_BITS -: 3]});
      host.release_cs();
      wait_conv(1'h1, 10);
      if (q.size() != 0) cur = q.pop_front();
      for (int i = 0; i < 7; i++) begin
         rd(1'h1, "int frame");
         check("sck driven", sck_oe, 1'h1);
         host.release_cs();
      end
      wait_conv(1'h0, 200);
      for (int i = 0; i < 40; i++) begin
         host.tick(10);
         rej = ~rej;
      end
      check("ext clock seen", ext_act, 1'h1);
      host.tick(400);
      check("ext clock lost", ext_act, 1'h0);
      conclude();
   end
endmodule : adc_serial_readout_sequencer_bench
